// ---- rtl/bosd_pkg.sv ----
// Notes on behaviour
// - Each instruction names a register 0..127 in bits 6:0, and bit forms name a bit 0..7 in bits 9:7.
// - The clear-bit op clears the chosen bit of the chosen register in one cycle, flags untouched.
// - The set-bit op sets the chosen bit of the chosen register in one cycle, flags untouched.
// - Read-modify-write ops decode in Q1, read in Q2, process in Q3 and write back in Q4.
// - The test-bit op goes on to the next instruction when the tested bit is one, flags untouched.
// - When the tested bit is zero, the fetched next instruction is dropped and a no-op runs instead.
// - A taken skip adds a second instruction cycle in which all four phases do nothing.
// - The test-bit op decodes in Q1, reads in Q2, evaluates in Q3 and writes nothing in Q4.
// - The increment-skip op adds one to the chosen register.
// - The increment result goes to the accumulator when the destination bit is 0, else to the register.
// - A zero increment result replaces the next instruction by a no-op, flags untouched.
package bosd_pkg;

  // ==========================================================================
  // Widths
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int BIT_W   = 3;

  // ==========================================================================
  // Field positions of the instruction word
  localparam int F_LSB      = 0;
  localparam int F_MSB      = 6;
  localparam int B_LSB      = 7;
  localparam int B_MSB      = 9;
  localparam int D_POS      = 7;
  localparam int BOP_LSB    = 10;
  localparam int BOP_MSB    = 13;
  localparam int IOP_LSB    = 8;
  localparam int IOP_MSB    = 13;

  // ==========================================================================
  // Opcodes of the top field
  localparam logic [3:0] OPC_CLR = 4'h4;
  localparam logic [3:0] OPC_SET = 4'h5;
  localparam logic [3:0] OPC_TST = 4'h6;
  localparam logic [5:0] OPC_INC = 6'h0f;

  // ==========================================================================
  // Reset values and constants
  localparam logic [DATA_W-1:0]  DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0]  ADDR_RST = 7'h00;
  localparam logic [BIT_W-1:0]   BIT_RST  = 3'h0;
  localparam logic [DATA_W-1:0]  INC_ONE  = 8'h01;
  localparam logic [DATA_W-1:0]  BIT_ONE  = 8'h01;

  // ==========================================================================
  // Timing: one instruction cycle is four clock phases
  localparam int PHASES_PER_CYCLE = 4;

  // ==========================================================================
  // Enumerations
  typedef enum logic [2:0] {
    OP_NONE,
    OP_CLR,
    OP_SET,
    OP_TST,
    OP_INC
  } bosd_op_e;

  typedef enum logic [1:0] {
    PH_Q1,
    PH_Q2,
    PH_Q3,
    PH_Q4
  } bosd_phase_e;

endpackage

// ---- rtl/bosd_phase.sv ----
`timescale 1ns/1ps
`default_nettype none
module bosd_phase
  import bosd_pkg::*;
(
  input  wire logic  clk,      // Core clock
  input  wire logic  rst_b,    // Async reset, active low
  output var  bosd_phase_e phase_r   // Current phase Q1..Q4
);

  // ==========================================================================
  // Phase sequencer
  // Steps Q1 to Q4 and back on every clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= PH_Q1;
    end else begin
      case (phase_r)
        PH_Q1:   phase_r <= PH_Q2;
        PH_Q2:   phase_r <= PH_Q3;
        PH_Q3:   phase_r <= PH_Q4;
        default: phase_r <= PH_Q1;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- rtl/bosd_alu.sv ----
`timescale 1ns/1ps
`default_nettype none
module bosd_alu
  import bosd_pkg::*;
(
  input  wire bosd_op_e          op,        // Decoded operation
  input  wire logic [DATA_W-1:0] operand,   // Register value read in Q2
  input  wire logic [BIT_W-1:0]  bit_sel,   // Bit index
  output logic      [DATA_W-1:0] result,    // Value to write
  output logic                   bit_val,   // Tested bit
  output logic                   is_zero    // Result is zero
);

  logic [DATA_W-1:0] mask;

  // Data path of the four operations
  always_comb begin
    mask    = BIT_ONE << bit_sel;
    bit_val = |(operand & mask);
    case (op)
      OP_CLR:  result = operand & ~mask;
      OP_SET:  result = operand | mask;
      OP_INC:  result = operand + INC_ONE;
      default: result = operand;
    endcase
    is_zero = (result == DATA_RST);
  end

endmodule
`default_nettype wire

// ---- rtl/bosd_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module bosd_core
  import bosd_pkg::*;
(
  input  wire logic               clk,          // Core clock, 250 MHz
  input  wire logic               rst_b,        // Async reset, active low
  input  wire logic [INSTR_W-1:0] instr,        // Fetched word, sampled in Q1
  input  wire logic [DATA_W-1:0]  rd_data,      // Register file read data
  output var  bosd_phase_e        phase_r,      // Current phase
  output logic                    rd_en_r,      // Register read strobe, Q2
  output logic      [ADDR_W-1:0]  file_addr_r,  // Register address
  output logic                    wr_en_r,      // Register write strobe, Q4
  output logic      [DATA_W-1:0]  wr_data_r,    // Register write data
  output logic                    w_we_r,       // Accumulator write strobe, Q4
  output logic      [DATA_W-1:0]  w_data_r,     // Accumulator write data
  output logic                    skip_req_r,   // Next fetch to be dropped, Q4
  output logic                    nop_cycle_r   // Whole cycle is a no-op
);

  // ==========================================================================
  // Internal state
  bosd_op_e          op_r;
  bosd_op_e          op_nxt;
  logic [BIT_W-1:0]  bit_r;
  logic              dest_r;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] alu_result;
  logic              alu_bit;
  logic              alu_zero;
  logic              skip_nxt;
  logic              to_file;

  // ==========================================================================
  // Phase sequencer
  bosd_phase u_phase (
    .clk     (clk),
    .rst_b   (rst_b),
    .phase_r (phase_r)
  );

  // ==========================================================================
  // Decode
  // Top field selects one of the four ops
  always_comb begin
    if (nop_cycle_r) begin
      op_nxt = OP_NONE;
    end else if (instr[BOP_MSB:BOP_LSB] == OPC_CLR) begin
      op_nxt = OP_CLR;
    end else if (instr[BOP_MSB:BOP_LSB] == OPC_SET) begin
      op_nxt = OP_SET;
    end else if (instr[BOP_MSB:BOP_LSB] == OPC_TST) begin
      op_nxt = OP_TST;
    end else if (instr[IOP_MSB:IOP_LSB] == OPC_INC) begin
      op_nxt = OP_INC;
    end else begin
      op_nxt = OP_NONE;
    end
  end

  // Latch op and operand fields in Q1
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_r        <= OP_NONE;
      bit_r       <= BIT_RST;
      dest_r      <= 1'b0;
      file_addr_r <= ADDR_RST;
    end else if (phase_r == PH_Q1) begin
      op_r        <= op_nxt;
      bit_r       <= instr[B_MSB:B_LSB];
      dest_r      <= instr[D_POS];
      file_addr_r <= instr[F_MSB:F_LSB];
    end
  end

  // ==========================================================================
  // Register read
  // Read strobe stands through Q2
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_en_r <= 1'b0;
    end else begin
      rd_en_r <= (phase_r == PH_Q1) && (op_nxt != OP_NONE);
    end
  end

  // Capture read data at the end of Q2
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= DATA_RST;
    end else if (rd_en_r) begin
      rd_data_r <= rd_data;
    end
  end

  // ==========================================================================
  // Process
  bosd_alu u_alu (
    .op      (op_r),
    .operand (rd_data_r),
    .bit_sel (bit_r),
    .result  (alu_result),
    .bit_val (alu_bit),
    .is_zero (alu_zero)
  );

  // Skip decision and destination select
  always_comb begin
    skip_nxt = ((op_r == OP_TST) && !alu_bit)
            || ((op_r == OP_INC) && alu_zero);
    to_file  = (op_r == OP_CLR) || (op_r == OP_SET)
            || ((op_r == OP_INC) && dest_r);
  end

  // ==========================================================================
  // Write back
  // Strobes stand through Q4 only; no flag is ever written
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_en_r <= 1'b0;
      w_we_r  <= 1'b0;
    end else begin
      wr_en_r <= (phase_r == PH_Q3) && to_file;
      w_we_r  <= (phase_r == PH_Q3) && (op_r == OP_INC) && !dest_r;
    end
  end

  // Write data, loaded in Q3
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_data_r <= DATA_RST;
      w_data_r  <= DATA_RST;
    end else if (phase_r == PH_Q3) begin
      wr_data_r <= alu_result;
      w_data_r  <= alu_result;
    end
  end

  // ==========================================================================
  // Skip control
  // Skip request stands in Q4; next cycle becomes all no-op
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      skip_req_r <= 1'b0;
    end else begin
      skip_req_r <= (phase_r == PH_Q3) && skip_nxt;
    end
  end

  // No-op cycle spans Q1..Q4 after a taken skip
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nop_cycle_r <= 1'b0;
    end else if (phase_r == PH_Q4) begin
      nop_cycle_r <= skip_req_r;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Helper: bit mask of the latched index
  logic [DATA_W-1:0] chk_mask;
  assign chk_mask = BIT_ONE << bit_r;

  addr_field_a: assert property (
    (phase_r == PH_Q1) |=> (file_addr_r == $past(instr[F_MSB:F_LSB]))
      && (bit_r == $past(instr[B_MSB:B_LSB])))
    else $error("operand fields not taken from the word");

  read_phase_a: assert property (
    rd_en_r |-> (phase_r == PH_Q2) && (op_r != OP_NONE))
    else $error("register read outside Q2");

  write_phase_a: assert property (
    wr_en_r |-> (phase_r == PH_Q4) && $past(rd_en_r, 2))
    else $error("register write not in Q4 after a Q2 read");

  clear_data_a: assert property (
    (wr_en_r && op_r == OP_CLR) |-> (wr_data_r == (rd_data_r & ~chk_mask)))
    else $error("clear-bit wrote wrong value");

  set_data_a: assert property (
    (wr_en_r && op_r == OP_SET) |-> (wr_data_r == (rd_data_r | chk_mask)))
    else $error("set-bit wrote wrong value");

  test_nowrite_a: assert property (
    (op_r == OP_TST) |-> !wr_en_r && !w_we_r)
    else $error("test-bit wrote a destination");

  test_skip_a: assert property (
    (phase_r == PH_Q4 && op_r == OP_TST) |-> (skip_req_r == !(|(rd_data_r & chk_mask))))
    else $error("test-bit skip decision wrong");

  skip_nop_a: assert property (
    (phase_r == PH_Q4 && skip_req_r) |=> nop_cycle_r [*4])
    else $error("taken skip did not give a four phase no-op");

  noskip_run_a: assert property (
    (phase_r == PH_Q4 && !skip_req_r) |=> !nop_cycle_r)
    else $error("no-op cycle without a skip");

  nop_quiet_a: assert property (
    nop_cycle_r |-> !rd_en_r && !wr_en_r && !w_we_r && !skip_req_r)
    else $error("activity during a no-op cycle");

  inc_value_a: assert property (
    ((wr_en_r || w_we_r) && op_r == OP_INC)
      |-> (w_data_r == rd_data_r + INC_ONE) && (wr_data_r == w_data_r))
    else $error("increment value wrong");

  inc_dest_a: assert property (
    (phase_r == PH_Q4 && op_r == OP_INC) |-> (wr_en_r == dest_r) && (w_we_r == !dest_r))
    else $error("increment destination wrong");

  inc_skip_a: assert property (
    (phase_r == PH_Q4 && op_r == OP_INC) |-> (skip_req_r == (w_data_r == DATA_RST)))
    else $error("increment skip decision wrong");

  // ==========================================================================
  // Assertions on sequencing, fields and strobes
  phase_step_a: assert property (
    (phase_r == PH_Q1) |=> (phase_r == PH_Q2) ##1 (phase_r == PH_Q3)
      ##1 (phase_r == PH_Q4) ##1 (phase_r == PH_Q1))
    else $error("phase sequence broken");

  field_hold_a: assert property (
    (phase_r != PH_Q1) |=> $stable(file_addr_r) && $stable(bit_r) && $stable(op_r))
    else $error("operand fields changed outside Q1");

  dest_latch_a: assert property (
    (phase_r == PH_Q1) |=> (dest_r == $past(instr[D_POS])))
    else $error("destination bit not taken from the word");

  read_demand_a: assert property (
    ((phase_r == PH_Q2) && (op_r != OP_NONE)) |-> rd_en_r)
    else $error("decoded op did not read in Q2");

  read_capture_a: assert property (
    rd_en_r |=> (rd_data_r == $past(rd_data)))
    else $error("read data not captured at end of Q2");

  read_hold_a: assert property (
    !rd_en_r |=> $stable(rd_data_r))
    else $error("read data changed without a read");

  wdata_hold_a: assert property (
    (phase_r != PH_Q3) |=> $stable(wr_data_r) && $stable(w_data_r))
    else $error("write data changed outside Q3");

  file_ops_a: assert property (
    wr_en_r
      |-> (op_r == OP_CLR) || (op_r == OP_SET) || ((op_r == OP_INC) && dest_r))
    else $error("register write by an op that must not write");

  acc_only_inc_a: assert property (
    w_we_r |-> (phase_r == PH_Q4) && (op_r == OP_INC) && !dest_r)
    else $error("accumulator write by a wrong op");

  write_demand_a: assert property (
    ((phase_r == PH_Q4) && ((op_r == OP_CLR) || (op_r == OP_SET)))
      |-> wr_en_r && !w_we_r && !skip_req_r)
    else $error("bit op did not write once in Q4");

  clear_bit_a: assert property (
    (wr_en_r && (op_r == OP_CLR)) |-> !wr_data_r[bit_r])
    else $error("clear-bit left the bit set");

  set_bit_a: assert property (
    (wr_en_r && (op_r == OP_SET)) |-> wr_data_r[bit_r])
    else $error("set-bit left the bit clear");

  unknown_quiet_a: assert property (
    (op_r == OP_NONE)
      |-> !rd_en_r && !wr_en_r && !w_we_r && !skip_req_r)
    else $error("strobe without a decoded op");

  // ==========================================================================
  // Assertions on skips
  skip_source_a: assert property (
    skip_req_r
      |-> (phase_r == PH_Q4) && ((op_r == OP_TST) || (op_r == OP_INC)))
    else $error("skip from an op that cannot skip");

  nop_drop_a: assert property (
    (nop_cycle_r && (phase_r == PH_Q1)) |=> (op_r == OP_NONE))
    else $error("dropped word was decoded");

  nop_end_a: assert property (
    (nop_cycle_r && (phase_r == PH_Q4)) |=> !nop_cycle_r)
    else $error("no-op cycle lasted past Q4");

  inc_wrap_a: assert property (
    ((phase_r == PH_Q4) && (op_r == OP_INC) && (rd_data_r == {DATA_W{1'b1}}))
      |-> (w_data_r == DATA_RST) && skip_req_r)
    else $error("increment of all ones did not wrap and skip");

  // ==========================================================================
  // Cover points of the main scenarios
  cover_clear_c: cover property (wr_en_r && op_r == OP_CLR);
  cover_test_skip_c: cover property (skip_req_r && op_r == OP_TST);
  cover_test_pass_c: cover property ((phase_r == PH_Q4) && (op_r == OP_TST) && !skip_req_r);
  cover_inc_wrap_c: cover property (skip_req_r && op_r == OP_INC && w_we_r);
  cover_inc_file_c: cover property (wr_en_r && op_r == OP_INC && !skip_req_r);

endmodule
`default_nettype wire

// ---- sim/bosd_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module bosd_bench
  import bosd_pkg::*;
;
  // ==========================================================================
  // Signals and register file model
  logic               clk;
  logic               rst_b;
  logic [INSTR_W-1:0] instr;
  logic [DATA_W-1:0]  rd_data;
  logic [DATA_W-1:0]  mem [0:127];
  bosd_phase_e        phase_r;
  logic               rd_en_r;
  logic [ADDR_W-1:0]  file_addr_r;
  logic               wr_en_r;
  logic [DATA_W-1:0]  wr_data_r;
  logic               w_we_r;
  logic [DATA_W-1:0]  w_data_r;
  logic               skip_req_r;
  logic               nop_cycle_r;
  int                 err_count;
  int                 n_checks;

  // Unselected file shows a pattern, never the last value
  assign rd_data = (rd_en_r === 1'b1) ? mem[file_addr_r] : 8'ha5;

  bosd_core u_dut (
    .clk         (clk),          // Core clock
    .rst_b       (rst_b),        // Reset
    .instr       (instr),        // Fetched word
    .rd_data     (rd_data),      // File read data
    .phase_r     (phase_r),      // Phase
    .rd_en_r     (rd_en_r),      // Read strobe
    .file_addr_r (file_addr_r),  // Address
    .wr_en_r     (wr_en_r),      // Write strobe
    .wr_data_r   (wr_data_r),    // Write data
    .w_we_r      (w_we_r),       // Accumulator strobe
    .w_data_r    (w_data_r),     // Accumulator data
    .skip_req_r  (skip_req_r),   // Skip taken
    .nop_cycle_r (nop_cycle_r)   // No-op cycle
  );

  // ==========================================================================
  // Compare and closing tasks
  task automatic chk1(input string what, input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic chk8(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // One instruction cycle, entered at the falling edge in Q1
  task automatic exec(input logic [13:0] word, input logic rd, input logic [7:0] res,
                      input logic wr, input logic w, input logic skip);
    chk8("phase", {6'h00, phase_r}, {6'h00, PH_Q1});
    instr = word;
    @(negedge clk);
    chk1("rd_en", rd_en_r, rd);
    if (rd) chk8("addr", {1'b0, file_addr_r}, {1'b0, word[6:0]});
    @(negedge clk);
    chk1("rd_en_q3", rd_en_r, 1'b0);
    chk1("wr_en_q3", wr_en_r, 1'b0);
    @(negedge clk);
    chk1("wr_en", wr_en_r, wr);
    chk1("w_we", w_we_r, w);
    chk1("skip", skip_req_r, skip);
    if (wr) chk8("wr_data", wr_data_r, res);
    if (w) chk8("w_data", w_data_r, res);
    if (wr) mem[word[6:0]] = res;
    @(negedge clk);
    if (skip) begin
      // A word that would write must be dropped
      instr = {OPC_SET, 3'h7, 7'h20};
      repeat (4) begin
        chk1("nop", nop_cycle_r, 1'b1);
        chk1("nop_rd", rd_en_r, 1'b0);
        chk1("nop_wr", wr_en_r | w_we_r | skip_req_r, 1'b0);
        @(negedge clk);
      end
    end
    chk1("nop_end", nop_cycle_r, 1'b0);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_bits();
    logic [7:0] e;
    mem[7'h7f] = 8'h00;
    for (int b = 0; b < 8; b++) begin
      e = mem[7'h7f] | (8'h01 << b);
      exec({OPC_SET, b[2:0], 7'h7f}, 1'b1, e, 1'b1, 1'b0, 1'b0);
    end
    for (int b = 0; b < 8; b++) begin
      e = mem[7'h7f] & ~(8'h01 << b);
      exec({OPC_CLR, b[2:0], 7'h7f}, 1'b1, e, 1'b1, 1'b0, 1'b0);
    end
    mem[7'h00] = 8'hc7;
    exec({OPC_CLR, 3'h7, 7'h00}, 1'b1, 8'h47, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic test_skip();
    mem[7'h20] = 8'h02;
    exec({OPC_TST, 3'h1, 7'h20}, 1'b1, 8'h00, 1'b0, 1'b0, 1'b0);
    exec({OPC_TST, 3'h0, 7'h20}, 1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
    exec({OPC_TST, 3'h7, 7'h20}, 1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
  endtask

  task automatic test_inc();
    mem[7'h30] = 8'h41;
    exec({OPC_INC, 1'b1, 7'h30}, 1'b1, 8'h42, 1'b1, 1'b0, 1'b0);
    exec({OPC_INC, 1'b0, 7'h30}, 1'b1, 8'h43, 1'b0, 1'b1, 1'b0);
    mem[7'h31] = 8'hff;
    exec({OPC_INC, 1'b1, 7'h31}, 1'b1, 8'h00, 1'b1, 1'b0, 1'b1);
    mem[7'h31] = 8'hff;
    exec({OPC_INC, 1'b0, 7'h31}, 1'b1, 8'h00, 1'b0, 1'b1, 1'b1);
    exec(14'h0e55, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic test_reset();
    mem[7'h40] = 8'h00;
    instr = {OPC_SET, 3'h7, 7'h40};
    repeat (2) @(negedge clk);
    rst_b = 1'b0;
    #1;
    chk8("rst_phase", {6'h00, phase_r}, {6'h00, PH_Q1});
    chk1("rst_wr", wr_en_r | rd_en_r | nop_cycle_r, 1'b0);
    @(negedge clk);
    rst_b = 1'b1;
    exec({OPC_TST, 3'h7, 7'h40}, 1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #20000;
    err_count++;
    conclude();
  end

  initial begin
    err_count = 0;
    n_checks = 0;
    rst_b = 1'b0;
    instr = 14'h0000;
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    test_bits();
    test_skip();
    test_inc();
    test_reset();
    conclude();
  end
endmodule
`default_nettype wire
